// >>> hw/cas_regs.svh
// register offsets, field positions, reset values for the auto-shutdown block
`ifndef CAS_REGS_SVH
`define CAS_REGS_SVH

// byte offsets
`define CAS_OFF_CTRL0 8'h00
`define CAS_OFF_SRC_SEL 8'h04
`define CAS_OFF_PIN_SEL 8'h08
`define CAS_OFF_STATUS 8'h0c
`define CAS_OFF_IRQ_STAT 8'h10
`define CAS_OFF_IRQ_CLR 8'h14
`define CAS_OFF_IRQ_EN 8'h18

// shutdown_control_reg0 fields
`define CAS_CTRL0_FORCE_BIT 0
`define CAS_CTRL0_ARE_BIT 1
`define CAS_CTRL0_LVL_AC_LSB 2
`define CAS_CTRL0_LVL_BD_LSB 4

// shutdown_source_select_reg fields
`define CAS_SRC_PIN_BIT 0
`define CAS_SRC_CMP2_BIT 1
`define CAS_SRC_CMP1_BIT 2
`define CAS_SRC_LC2_BIT 3

// status fields
`define CAS_STAT_HOLD_BIT 1
`define CAS_STAT_LVL_LSB 4

// interrupt event bits
`define CAS_IRQ_ENTER_BIT 0
`define CAS_IRQ_RESUME_BIT 1

// reset values
`define CAS_CTRL0_RST 8'h00
`define CAS_SRC_SEL_RST 4'h0
`define CAS_PIN_SEL_RST 4'h0
`define CAS_IRQ_EN_RST 2'h0

// AXI responses
`define CAS_RESP_OKAY 2'h0
`define CAS_RESP_SLVERR 2'h2

`endif

// >>> hw/cas_pkg.sv
// types shared by the auto-shutdown block
package cas_pkg;

	typedef logic [1:0] cas_lvl_t;

	// override choice per output pair
	typedef enum logic [1:0] {
		CAS_OVR_LOW = 2'h0,
		CAS_OVR_HIGH = 2'h1,
		CAS_OVR_TRI = 2'h2,
		CAS_OVR_INACTIVE = 2'h3
	} cas_ovr_e;

	// register decode result
	typedef enum logic [2:0] {
		CAS_REG_CTRL0,
		CAS_REG_SRC_SEL,
		CAS_REG_PIN_SEL,
		CAS_REG_STATUS,
		CAS_REG_IRQ_STAT,
		CAS_REG_IRQ_CLR,
		CAS_REG_IRQ_EN,
		CAS_REG_NONE
	} cas_reg_e;

	// four external fault levels, active low
	typedef struct packed {
		logic lc2;
		logic cmp1;
		logic cmp2;
		logic pin;
	} cas_src_s;

	// output drive of the four outputs a..d
	typedef struct packed {
		logic [3:0] level;
		logic [3:0] oe;
	} cas_drive_s;

	// software-visible control
	typedef struct packed {
		logic force_flag;
		logic auto_restart;
		cas_ovr_e lvl_ac;
		cas_ovr_e lvl_bd;
		logic [3:0] src_en;
		logic [3:0] pin_sel;
		logic [1:0] irq_stat;
		logic [1:0] irq_en;
	} cas_ctrl_s;

	// AXI4-Lite slave state
	typedef struct packed {
		logic aw_got;
		logic [7:0] awaddr;
		logic w_got;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} cas_axi_s;

	// whole state of the top module
	typedef struct packed {
		cas_ctrl_s ctrl;
		cas_axi_s axi;
		logic hold;
		cas_drive_s drive;
	} cas_state_s;

endpackage

// >>> hw/cas_sync.sv
// three-stage synchroniser with agreement filter
`timescale 1ns/1ps
module cas_sync #(
	parameter int WIDTH = 4,
	parameter logic [WIDTH-1:0] RST_VAL = '1
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// raw and filtered levels
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] level_out
);

	logic [WIDTH-1:0] s1_r;
	logic [WIDTH-1:0] s2_r;
	logic [WIDTH-1:0] s3_r;
	logic [WIDTH-1:0] level_r;

	// level follows only where stages two and three agree
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			s1_r <= RST_VAL;
			s2_r <= RST_VAL;
			s3_r <= RST_VAL;
			level_r <= RST_VAL;
		end else begin
			s1_r <= async_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
			level_r <= (s2_r & s3_r) | (level_r & (s2_r ^ s3_r));
		end
	end

	assign level_out = level_r;

endmodule // cas_sync

// >>> hw/cas_shutdown.sv
// auto-shutdown control of a complementary waveform generator, AXI4-Lite registers
//
// Operation
// [R1] Entering shutdown overrides the output levels at once, without software or waveform events.
// [R2] After shutdown is cleared either way, the overrides stay until the next rising event.
// [R3] Writing one to the shutdown force flag puts the generator into shutdown.
// [R4] A selected external fault going true drops the output drive to the override levels at once; here cas_sync delays the drop to the fifth clock edge.
// [R5] Any mix of enabled sources is accepted; each requests shutdown while low, by level.
// [R6] Four sources (selected pin, comparator two, comparator one, logic cell two), each with its enable.
// [R7] The A/C override field sets outputs A and C; the B/D field sets outputs B and D.
// [R8] Each pair may be forced low, forced high, tri-stated, or put to the inactive state.
// [R9] Polarity applies only to the inactive choice; forced low and high bypass it.
// [R10] The auto-restart enable selects software restart or automatic restart.
// [R11] Without auto-restart, software clears the force flag and output resumes at the next rising event.
// [R12] A software clear of the force flag works only while no enabled fault input is true.
// [R13] With auto-restart, the flag clears itself once faults are gone; output resumes at the next rising event.
// [R14] The force flag is set whenever an enabled external source causes shutdown.
// [R15] Rising and falling events are single-cycle pulses from the generator.
`timescale 1ns/1ps
`include "cas_regs.svh"
module cas_shutdown
	import cas_pkg::*;
#(
	parameter int PINS = 16
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// AXI4-Lite write address
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	// AXI4-Lite write data
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	// AXI4-Lite write response
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output logic [1:0] s_axi_bresp,
	// AXI4-Lite read address
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	// AXI4-Lite read data
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	// fault sources, asynchronous, active low
	input wire logic [PINS-1:0] shutdown_pins_in,
	input wire logic comparator_two_output_in,
	input wire logic comparator_one_output_in,
	input wire logic logic_cell_two_output_in,
	// generator side, same clock
	input wire logic rise_event_in,
	input wire logic fall_event_in,
	input wire logic [3:0] wave_in,
	input wire logic [3:0] polarity_in,
	// outputs a..d to the power stage
	output logic [3:0] wave_out,
	output logic [3:0] wave_oe_out,
	// status and interrupt
	output logic shutdown_active_out,
	output logic irq_out
);

	//------------------------------------------------------------
	// decode
	//------------------------------------------------------------

	function automatic cas_reg_e cas_decode(input logic [7:0] addr);
		unique case (addr)
			`CAS_OFF_CTRL0: cas_decode = CAS_REG_CTRL0;
			`CAS_OFF_SRC_SEL: cas_decode = CAS_REG_SRC_SEL;
			`CAS_OFF_PIN_SEL: cas_decode = CAS_REG_PIN_SEL;
			`CAS_OFF_STATUS: cas_decode = CAS_REG_STATUS;
			`CAS_OFF_IRQ_STAT: cas_decode = CAS_REG_IRQ_STAT;
			`CAS_OFF_IRQ_CLR: cas_decode = CAS_REG_IRQ_CLR;
			`CAS_OFF_IRQ_EN: cas_decode = CAS_REG_IRQ_EN;
			default: cas_decode = CAS_REG_NONE;
		endcase
	endfunction

	// override level for one output of a pair
	function automatic logic [1:0] cas_override(input cas_ovr_e sel, input logic pol);
		// bit1 = oe, bit0 = level
		unique case (sel)
			CAS_OVR_LOW: cas_override = 2'h2; // see [R9]
			CAS_OVR_HIGH: cas_override = 2'h3; // see [R9]
			CAS_OVR_TRI: cas_override = 2'h0;
			CAS_OVR_INACTIVE: cas_override = {1'b1, pol}; // see [R9]
		endcase
	endfunction

	//------------------------------------------------------------
	// fault inputs
	//------------------------------------------------------------

	cas_state_s state_r;
	cas_state_s state_nxt;
	cas_src_s src_raw;
	cas_src_s src_lvl;
	logic fault;
	logic [1:0] irq_event;
	cas_reg_e wr_reg;
	cas_reg_e rd_reg;
	logic wr_fire;
	logic rd_fire;
	logic wr_lane0;
	logic [31:0] rd_word;

	assign src_raw.pin = shutdown_pins_in[state_r.ctrl.pin_sel[$clog2(PINS)-1:0]]; // see [R6]
	assign src_raw.cmp2 = comparator_two_output_in;
	assign src_raw.cmp1 = comparator_one_output_in;
	assign src_raw.lc2 = logic_cell_two_output_in;

	cas_sync #(
		.WIDTH(4),
		.RST_VAL(4'hf)
	) u_sync (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.async_in(src_raw),
		.level_out(src_lvl)
	);

	// any enabled source low, by level
	assign fault = |(state_r.ctrl.src_en & ~src_lvl); // see [R5] [R6]

	//------------------------------------------------------------
	// bus handshake
	//------------------------------------------------------------

	assign s_axi_awready = !state_r.axi.aw_got && !state_r.axi.bvalid;
	assign s_axi_wready = !state_r.axi.w_got && !state_r.axi.bvalid;
	assign s_axi_bvalid = state_r.axi.bvalid;
	assign s_axi_bresp = state_r.axi.bresp;
	assign s_axi_arready = !state_r.axi.rvalid;
	assign s_axi_rvalid = state_r.axi.rvalid;
	assign s_axi_rdata = state_r.axi.rdata;
	assign s_axi_rresp = state_r.axi.rresp;

	assign wr_fire = state_r.axi.aw_got && state_r.axi.w_got && !state_r.axi.bvalid;
	assign wr_reg = cas_decode(state_r.axi.awaddr);
	assign wr_lane0 = wr_fire && state_r.axi.wstrb[0];
	assign rd_fire = s_axi_arvalid && !state_r.axi.rvalid;
	assign rd_reg = cas_decode(s_axi_araddr);

	// read data
	always_comb begin
		rd_word = 32'h0;
		unique case (rd_reg)
			CAS_REG_CTRL0: begin
				rd_word[`CAS_CTRL0_FORCE_BIT] = state_r.ctrl.force_flag; // see [R14]
				rd_word[`CAS_CTRL0_ARE_BIT] = state_r.ctrl.auto_restart;
				rd_word[`CAS_CTRL0_LVL_AC_LSB +: 2] = state_r.ctrl.lvl_ac;
				rd_word[`CAS_CTRL0_LVL_BD_LSB +: 2] = state_r.ctrl.lvl_bd;
			end
			CAS_REG_SRC_SEL: rd_word[3:0] = state_r.ctrl.src_en;
			CAS_REG_PIN_SEL: rd_word[3:0] = state_r.ctrl.pin_sel;
			CAS_REG_STATUS: begin
				rd_word[0] = fault;
				rd_word[`CAS_STAT_HOLD_BIT] = state_r.hold;
				rd_word[`CAS_STAT_LVL_LSB +: 4] = src_lvl;
			end
			CAS_REG_IRQ_STAT: rd_word[1:0] = state_r.ctrl.irq_stat;
			CAS_REG_IRQ_CLR: rd_word = 32'h0;
			CAS_REG_IRQ_EN: rd_word[1:0] = state_r.ctrl.irq_en;
			CAS_REG_NONE: rd_word = 32'h0;
		endcase
	end

	//------------------------------------------------------------
	// next state
	//------------------------------------------------------------

	always_comb begin
		state_nxt = state_r;
		irq_event = 2'h0;

		// write address and data taken in either order
		if (s_axi_awvalid && s_axi_awready) begin
			state_nxt.axi.aw_got = 1'b1;
			state_nxt.axi.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			state_nxt.axi.w_got = 1'b1;
			state_nxt.axi.wdata = s_axi_wdata;
			state_nxt.axi.wstrb = s_axi_wstrb;
		end
		if (wr_fire) begin
			state_nxt.axi.aw_got = 1'b0;
			state_nxt.axi.w_got = 1'b0;
			state_nxt.axi.bvalid = 1'b1;
			state_nxt.axi.bresp = (wr_reg == CAS_REG_NONE) ? `CAS_RESP_SLVERR : `CAS_RESP_OKAY;
		end
		if (state_r.axi.bvalid && s_axi_bready) begin
			state_nxt.axi.bvalid = 1'b0;
		end

		// read
		if (rd_fire) begin
			state_nxt.axi.rvalid = 1'b1;
			state_nxt.axi.rdata = rd_word;
			state_nxt.axi.rresp = (rd_reg == CAS_REG_NONE) ? `CAS_RESP_SLVERR : `CAS_RESP_OKAY;
		end
		if (state_r.axi.rvalid && s_axi_rready) begin
			state_nxt.axi.rvalid = 1'b0;
		end

		// register writes, all fields in byte lane 0
		if (wr_lane0) begin
			unique case (wr_reg)
				CAS_REG_CTRL0: begin
					state_nxt.ctrl.auto_restart = state_r.axi.wdata[`CAS_CTRL0_ARE_BIT]; // see [R10]
					state_nxt.ctrl.lvl_ac = cas_ovr_e'(state_r.axi.wdata[`CAS_CTRL0_LVL_AC_LSB +: 2]);
					state_nxt.ctrl.lvl_bd = cas_ovr_e'(state_r.axi.wdata[`CAS_CTRL0_LVL_BD_LSB +: 2]);
					if (state_r.axi.wdata[`CAS_CTRL0_FORCE_BIT]) begin
						state_nxt.ctrl.force_flag = 1'b1; // see [R3]
					end else if (!fault) begin
						state_nxt.ctrl.force_flag = 1'b0; // see [R11] [R12]
					end
				end
				CAS_REG_SRC_SEL: state_nxt.ctrl.src_en = state_r.axi.wdata[3:0];
				CAS_REG_PIN_SEL: state_nxt.ctrl.pin_sel = state_r.axi.wdata[3:0];
				CAS_REG_IRQ_CLR: state_nxt.ctrl.irq_stat = state_r.ctrl.irq_stat & ~state_r.axi.wdata[1:0];
				CAS_REG_IRQ_EN: state_nxt.ctrl.irq_en = state_r.axi.wdata[1:0];
				default: state_nxt.ctrl = state_nxt.ctrl;
			endcase
		end

		// automatic clear once every enabled fault is gone
		if (state_r.ctrl.auto_restart && !fault && state_r.ctrl.force_flag) begin
			state_nxt.ctrl.force_flag = 1'b0; // see [R13]
		end

		// an external fault sets the flag, winning over any clear
		if (fault) begin
			state_nxt.ctrl.force_flag = 1'b1; // see [R14] [R4]
		end

		// override hold: set with shutdown, dropped at the first rising event after the clear
		if (state_nxt.ctrl.force_flag) begin
			state_nxt.hold = 1'b1; // see [R1]
		end else if (state_r.hold && !state_r.ctrl.force_flag && rise_event_in) begin
			state_nxt.hold = 1'b0; // see [R2] [R11] [R13] [R15]
		end

		// events for the interrupt status
		irq_event[`CAS_IRQ_ENTER_BIT] = state_nxt.hold && !state_r.hold;
		irq_event[`CAS_IRQ_RESUME_BIT] = state_r.hold && !state_nxt.hold;
		state_nxt.ctrl.irq_stat = state_nxt.ctrl.irq_stat | irq_event;

		// output drive latches
		if (state_nxt.hold) begin
			// levels written together with the force bit apply at once
			{state_nxt.drive.oe[0], state_nxt.drive.level[0]} =
				cas_override(state_nxt.ctrl.lvl_ac, polarity_in[0]); // see [R7] [R8] [R4] [R1]
			{state_nxt.drive.oe[2], state_nxt.drive.level[2]} =
				cas_override(state_nxt.ctrl.lvl_ac, polarity_in[2]); // see [R7] [R8]
			{state_nxt.drive.oe[1], state_nxt.drive.level[1]} =
				cas_override(state_nxt.ctrl.lvl_bd, polarity_in[1]); // see [R7] [R8]
			{state_nxt.drive.oe[3], state_nxt.drive.level[3]} =
				cas_override(state_nxt.ctrl.lvl_bd, polarity_in[3]); // see [R7] [R8]
		end else begin
			state_nxt.drive.oe = 4'hf;
			state_nxt.drive.level = wave_in;
		end
	end

	//------------------------------------------------------------
	// state register
	//------------------------------------------------------------

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state_r.ctrl.force_flag <= 1'(`CAS_CTRL0_RST >> `CAS_CTRL0_FORCE_BIT);
			state_r.ctrl.auto_restart <= 1'(`CAS_CTRL0_RST >> `CAS_CTRL0_ARE_BIT);
			state_r.ctrl.lvl_ac <= cas_ovr_e'(2'(`CAS_CTRL0_RST >> `CAS_CTRL0_LVL_AC_LSB));
			state_r.ctrl.lvl_bd <= cas_ovr_e'(2'(`CAS_CTRL0_RST >> `CAS_CTRL0_LVL_BD_LSB));
			state_r.ctrl.src_en <= `CAS_SRC_SEL_RST;
			state_r.ctrl.pin_sel <= `CAS_PIN_SEL_RST;
			state_r.ctrl.irq_stat <= 2'h0;
			state_r.ctrl.irq_en <= `CAS_IRQ_EN_RST;
			state_r.axi <= '0;
			state_r.hold <= 1'b0;
			state_r.drive.level <= 4'h0;
			state_r.drive.oe <= 4'h0;
		end else begin
			state_r <= state_nxt;
		end
	end

	//------------------------------------------------------------
	// outputs
	//------------------------------------------------------------

	assign wave_out = state_r.drive.level;
	assign wave_oe_out = state_r.drive.oe;
	assign shutdown_active_out = state_r.hold;
	assign irq_out = |(state_r.ctrl.irq_stat & state_r.ctrl.irq_en);

	// fall events and protection bits need no action here
	logic unused_ok;
	assign unused_ok = fall_event_in ^ (^s_axi_awprot) ^ (^s_axi_arprot);

endmodule // cas_shutdown

// >>> sim/cas_stage_model.sv
// power stage model on outputs a..d
`timescale 1ns/1ps
module cas_stage_model (
	// clock
	input wire logic clk_in,
	// drive from the block
	input wire logic [3:0] level_in,
	input wire logic [3:0] oe_in,
	// pad levels seen by the stage
	output logic [3:0] pad_out
);
	logic [3:0] last_r;
	// released pads have no pull: they show the inverse of the last driven level
	assign pad_out = (oe_in & level_in) | (~oe_in & ~last_r);
	always_ff @(posedge clk_in) begin
		last_r <= (oe_in & level_in) | (~oe_in & last_r);
	end
endmodule // cas_stage_model

// >>> sim/cas_shutdown_chk.sv
// port assertions of the auto-shutdown block
`timescale 1ns/1ps
module cas_shutdown_chk
	import cas_pkg::*;
#(
	parameter int PINS = 16
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// bus handshakes
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// sources and generator
	input wire logic [PINS-1:0] shutdown_pins_in,
	input wire logic comparator_two_output_in,
	input wire logic comparator_one_output_in,
	input wire logic logic_cell_two_output_in,
	input wire logic rise_event_in,
	input wire logic [3:0] wave_in,
	// outputs
	input wire logic [3:0] wave_out,
	input wire logic [3:0] wave_oe_out,
	input wire logic shutdown_active_out,
	input wire logic irq_out
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);
	// ----
	// cycles since a source was low
	// ----
	logic [3:0] quiet_r;
	logic [3:0] quiet_nxt;
	logic any_low;
	assign any_low = !(&shutdown_pins_in && comparator_two_output_in && comparator_one_output_in
		&& logic_cell_two_output_in);
	always_comb begin
		quiet_nxt = quiet_r + {3'h0, quiet_r != 4'hf};
		if (any_low) begin
			quiet_nxt = 4'h0;
		end
	end
	always_ff @(posedge clk_in) begin
		quiet_r <= rst_in ? 4'hf : quiet_nxt;
	end
	// ----
	// assertions
	// ----
	sequence s_enter;
		!shutdown_active_out ##1 shutdown_active_out;
	endsequence
	sequence s_leave;
		shutdown_active_out ##1 !shutdown_active_out;
	endsequence
	AST_PASS: assert property (
		!shutdown_active_out && !$past(rst_in) |-> wave_out == $past(wave_in) && wave_oe_out == 4'hf)
		else $error("outputs differ from generator while not held");
	AST_RESUME: assert property (
		s_leave |-> $past(rise_event_in))
		else $error("override released without rising event");
	AST_ENTER: assert property (
		s_enter |-> s_axi_bvalid || quiet_r < 4'h8)
		else $error("shutdown entered without cause");
	AST_B_ANSWER: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write response late");
	AST_B_DROP: assert property (
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write response not retired");
	AST_R_ANSWER: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer late");
	AST_R_DROP: assert property (
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
		else $error("read answer not retired");
	AST_IRQ: assert property (
		$rose(irq_out) && !$past(rst_in) |-> $changed(shutdown_active_out) || s_axi_bvalid)
		else $error("interrupt rose without event");
endmodule // cas_shutdown_chk

bind cas_shutdown cas_shutdown_chk #(.PINS(PINS)) chk_u (.*);

// >>> sim/cas_shutdown_bench.sv
// self-checking bench for the auto-shutdown block
`timescale 1ns/1ps
`include "cas_regs.svh"
module cas_shutdown_bench;
	import cas_pkg::*;
	// ----
	// signals
	// ----
	logic clk_in, rst_in, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb, src_n, wave_in, polarity_in, wave_out, wave_oe_out, pad;
	logic [2:0] s_axi_awprot, s_axi_arprot;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr;
	logic [15:0] shutdown_pins_in;
	logic comparator_two_output_in, comparator_one_output_in, logic_cell_two_output_in;
	logic rise_event_in, fall_event_in, shutdown_active_out, irq_out;
	int err_count, checks_done;
	assign shutdown_pins_in = {10'h3ff, src_n[0], 5'h1f};
	assign comparator_two_output_in = src_n[1];
	assign comparator_one_output_in = src_n[2];
	assign logic_cell_two_output_in = src_n[3];
	cas_shutdown #(.PINS(16)) dut_u (.*);
	cas_stage_model stage_u (.clk_in(clk_in), .level_in(wave_out), .oe_in(wave_oe_out), .pad_out(pad));
	// ----
	// helpers
	// ----
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic tick(inout int n);
		@(negedge clk_in);
		n++;
		if (n > 40) begin
			err_count++;
			end_sim();
		end
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		int n;
		logic aw, w;
		n = 0;
		aw = 1'b0;
		w = 1'b0;
		@(posedge clk_in);
		s_axi_awvalid <= 1'b1;
		s_axi_awaddr <= a;
		s_axi_wvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_bready <= 1'b1;
		while (!(aw && w)) begin
			tick(n);
			aw |= s_axi_awready;
			w |= s_axi_wready;
			@(posedge clk_in);
			if (aw) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
		end
		do tick(n); while (s_axi_bvalid !== 1'b1);
		rr = s_axi_bresp;
		@(posedge clk_in);
		s_axi_bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [7:0] a);
		int n;
		n = 0;
		@(posedge clk_in);
		s_axi_arvalid <= 1'b1;
		s_axi_araddr <= a;
		s_axi_rready <= 1'b1;
		do tick(n); while (s_axi_arready !== 1'b1);
		@(posedge clk_in);
		s_axi_arvalid <= 1'b0;
		do tick(n); while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		rr = s_axi_rresp;
		@(posedge clk_in);
		s_axi_rready <= 1'b0;
	endtask
	task automatic rise_pulse();
		@(posedge clk_in);
		rise_event_in <= 1'b1;
		@(posedge clk_in);
		rise_event_in <= 1'b0;
		@(negedge clk_in);
	endtask
	// expected {oe, level} for override codes
	function automatic logic [7:0] ovr(input logic [1:0] ac, input logic [1:0] bd);
		logic [1:0] k;
		ovr = 8'h0;
		for (int i = 0; i < 4; i++) begin
			k = i[0] ? bd : ac;
			ovr[i + 4] = k != CAS_OVR_TRI;
			ovr[i] = k == CAS_OVR_HIGH || (k == CAS_OVR_INACTIVE && polarity_in[i]);
		end
	endfunction
	// ----
	// scenarios
	// ----
	task automatic t_regs();
		logic [7:0] offs [6] = '{`CAS_OFF_CTRL0, `CAS_OFF_SRC_SEL, `CAS_OFF_PIN_SEL, `CAS_OFF_IRQ_STAT,
			`CAS_OFF_IRQ_CLR, `CAS_OFF_IRQ_EN};
		foreach (offs[i]) begin
			axi_rd(offs[i]);
			check({rd[29:0], rr}, 32'h0);
		end
		axi_rd(8'h40);
		check({rd[29:0], rr}, 32'(`CAS_RESP_SLVERR));
		axi_wr(8'h40, 32'h1);
		check(32'(rr), 32'(`CAS_RESP_SLVERR));
		s_axi_wstrb <= 4'h0;
		axi_wr(`CAS_OFF_CTRL0, 32'h1);
		check(32'(rr), 32'(`CAS_RESP_OKAY));
		s_axi_wstrb <= 4'hf;
		axi_rd(`CAS_OFF_CTRL0);
		@(negedge clk_in);
		check({rd[30:0], shutdown_active_out}, 32'h0);
		$display("test regs done");
	endtask
	task automatic t_codes();
		logic [7:0] e;
		axi_wr(`CAS_OFF_IRQ_EN, 32'h1);
		wave_in <= 4'h9;
		for (int c = 0; c < 4; c++) begin
			e = ovr(2'(c), 2'(3 - c));
			axi_wr(`CAS_OFF_CTRL0, 32'((3 - c) * 16 + c * 4 + 1));
			@(negedge clk_in);
			check(32'({wave_oe_out, pad & e[7:4], shutdown_active_out, irq_out}), 32'({e, 2'h3}));
			axi_wr(`CAS_OFF_IRQ_CLR, 32'h3);
			axi_wr(`CAS_OFF_CTRL0, 32'((3 - c) * 16 + c * 4));
			@(negedge clk_in);
			check(32'({wave_oe_out, pad & e[7:4], shutdown_active_out, irq_out}), 32'({e, 2'h2}));
			rise_pulse();
			check(32'({wave_oe_out, pad, shutdown_active_out, irq_out}), 32'h3e4);
			axi_rd(`CAS_OFF_IRQ_STAT);
			check(rd, 32'h2);
			axi_wr(`CAS_OFF_IRQ_CLR, 32'h3);
		end
		$display("test codes done");
	endtask
	task automatic t_src();
		int n;
		logic [31:0] m;
		axi_wr(`CAS_OFF_PIN_SEL, 32'h5);
		for (int i = 0; i < 4; i++) begin
			m = i > 0 ? 32'h2 : 32'h0;
			n = 0;
			axi_wr(`CAS_OFF_CTRL0, m);
			axi_wr(`CAS_OFF_SRC_SEL, 32'(4'hf ^ (4'h1 << i)));
			src_n[i] <= 1'b0;
			repeat (8) @(negedge clk_in);
			check(32'(shutdown_active_out), 32'h0);
			axi_wr(`CAS_OFF_SRC_SEL, 32'(4'h1 << i));
			do tick(n); while (shutdown_active_out !== 1'b1);
			check(32'({wave_oe_out, pad}), 32'hf0);
			axi_wr(`CAS_OFF_CTRL0, m);
			axi_rd(`CAS_OFF_CTRL0);
			check(rd, m | 32'h1);
			axi_rd(`CAS_OFF_STATUS);
			check(rd, 32'({4'hf ^ (4'h1 << i), 4'h3}));
			src_n[i] <= 1'b1;
			repeat (8) @(negedge clk_in);
			if (i == 0) axi_wr(`CAS_OFF_CTRL0, m);
			axi_rd(`CAS_OFF_CTRL0);
			@(negedge clk_in);
			check({rd[30:0], shutdown_active_out}, {m[30:0], 1'b1});
			rise_pulse();
			check(32'(shutdown_active_out), 32'h0);
		end
		$display("test sources done");
	endtask
	// ----
	// main sequence
	// ----
	initial begin
		clk_in = 1'b0;
		forever #2 clk_in = ~clk_in;
	end
	initial begin
		rst_in = 1'b1;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot} = 22'h0;
		s_axi_wdata = 32'h0;
		s_axi_wstrb = 4'hf;
		src_n = 4'hf;
		wave_in = 4'h6;
		polarity_in = 4'h5;
		{rise_event_in, fall_event_in} = 2'h0;
		err_count = 0;
		checks_done = 0;
		repeat (8) @(posedge clk_in);
		rst_in <= 1'b0;
		t_regs();
		t_codes();
		t_src();
		end_sim();
	end
endmodule // cas_shutdown_bench
